// ### ssc_front.sv
// control-input front end of a pipelined synchronous static ram
`timescale 1ns/100ps
`include "ssc_defs.svh"

module ssc_front #(
   parameter int ADDR_W     = `SSC_ADDR_W_DFLT,
   parameter int LANES      = `SSC_LANES_DFLT,
   parameter bit HAS_PARITY = `SSC_PARITY_DFLT
) (
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   input  wire logic              addr_bit_zero,
   input  wire logic              addr_bit_one,
   input  wire logic [ADDR_W-3:0] upper_address_inputs,
   input  wire logic              lane_a_write_en_n,
   input  wire logic              lane_b_write_en_n,
   input  wire logic              lane_c_write_en_n,
   input  wire logic              lane_d_write_en_n,
   input  wire logic              select_one_n,
   input  wire logic              select_two_n,
   input  wire logic              select_three_high,
   input  wire logic              clock_enable_n,
   input  wire logic              snooze_request,
   input  wire logic              write_select_n,
   input  wire logic              advance_or_load,
   input  wire logic              burst_order_select,
   input  wire logic              output_enable_n,
   input  wire logic [7:0]        data_lane_a_in,
   input  wire logic [7:0]        data_lane_b_in,
   input  wire logic [7:0]        data_lane_c_in,
   input  wire logic [7:0]        data_lane_d_in,
   output logic      [7:0]        data_lane_a_out,
   output logic      [7:0]        data_lane_b_out,
   output logic      [7:0]        data_lane_c_out,
   output logic      [7:0]        data_lane_d_out,
   output logic                   data_lane_a_oe,
   output logic                   data_lane_b_oe,
   output logic                   data_lane_c_oe,
   output logic                   data_lane_d_oe,
   input  wire logic              parity_lane_a_in,
   input  wire logic              parity_lane_b_in,
   input  wire logic              parity_lane_c_in,
   input  wire logic              parity_lane_d_in,
   output logic                   parity_lane_a_out,
   output logic                   parity_lane_b_out,
   output logic                   parity_lane_c_out,
   output logic                   parity_lane_d_out,
   output logic                   parity_lane_a_oe,
   output logic                   parity_lane_b_oe,
   output logic                   parity_lane_c_oe,
   output logic                   parity_lane_d_oe
);

   localparam int LMAX = `SSC_LANES_MAX;
   localparam int SW   = `SSC_SLOT_W;
   localparam int BW   = `SSC_BYTE_W;

   // ----------------------------------------------------------------------
   // state record: one struct, one comb fill, one register
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic                       active;    // last load selected the part
      ssc_pkg::ssc_op_t           op;        // type of the running burst
      logic [ADDR_W-1:0]          base;      // loaded external address
      logic [`SSC_BURST_W-1:0]    cnt;       // burst counter
      logic                       c1_valid;
      ssc_pkg::ssc_op_t           c1_op;
      logic [ADDR_W-1:0]          c1_addr;
      logic [LMAX-1:0]            c1_lanes;
      logic                       c2_valid;
      ssc_pkg::ssc_op_t           c2_op;
      logic [ADDR_W-1:0]          c2_addr;
      logic [LMAX-1:0]            c2_lanes;
      logic                       drive;     // read data on the output stage
      logic [LMAX-1:0][BW-1:0]    dout;
      logic [LMAX-1:0]            pout;
   } ssc_state_t;

   ssc_state_t q;
   ssc_state_t next_q;

   // ----------------------------------------------------------------------
   // pin gathering
   // ----------------------------------------------------------------------
   logic                  go;
   logic                  load;
   logic                  selected;
   logic [ADDR_W-1:0]     addr_in;
   logic [LMAX-1:0]       lane_en;
   logic [LMAX-1:0]       lane_mask;
   logic [LMAX-1:0]       lane_oe;
   logic [LMAX*SW-1:0]    wr_data;
   logic [LMAX*SW-1:0]    rd_data;
   logic                  mem_wr;
   ssc_pkg::ssc_order_t   order;

   // snooze overrides everything, so a frozen or sleeping part steps nothing
   assign go       = !clock_enable_n && !snooze_request;
   assign load     = !advance_or_load;
   assign selected = !select_one_n && !select_two_n && select_three_high;
   assign addr_in  = {upper_address_inputs, addr_bit_one, addr_bit_zero};
   assign order    = burst_order_select ? ssc_pkg::ssc_order_interleave
                                        : ssc_pkg::ssc_order_linear;

   // lanes above the built width are never enabled nor driven
   assign lane_mask = (LANES == LMAX) ? 4'hf : 4'h3;
   assign lane_en   = ~{lane_d_write_en_n, lane_c_write_en_n,
                        lane_b_write_en_n, lane_a_write_en_n} & lane_mask;

   // write slot per lane: byte in the low bits, parity on top
   assign wr_data = {parity_lane_d_in & HAS_PARITY, data_lane_d_in,
                     parity_lane_c_in & HAS_PARITY, data_lane_c_in,
                     parity_lane_b_in & HAS_PARITY, data_lane_b_in,
                     parity_lane_a_in & HAS_PARITY, data_lane_a_in};

   // write lands on the edge that brings its data, two steps after load
   assign mem_wr = go && q.c2_valid && (q.c2_op == ssc_pkg::ssc_op_write);

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   ssc_mem #(
      .ADDR_W (ADDR_W),
      .LANES  (LMAX),
      .SLOT_W (SW)
   ) u_mem (
      .clk_sys (clk_sys),
      .rd_en   (go),
      .rd_addr (q.c1_addr),
      .rd_data (rd_data),
      .wr_en   (mem_wr),
      .wr_addr (q.c2_addr),
      .wr_lane (q.c2_lanes),
      .wr_data (wr_data)
   );

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic [`SSC_BURST_W-1:0] step;
      step   = q.cnt + 2'd1;
      next_q = q;
      if (go) begin
         if (load) begin
            // selects and read/write only matter here
            next_q.active   = selected;
            next_q.op       = write_select_n ? ssc_pkg::ssc_op_read
                                             : ssc_pkg::ssc_op_write;
            next_q.base     = addr_in;
            next_q.cnt      = '0;
            next_q.c1_valid = selected;
            next_q.c1_op    = next_q.op;
            next_q.c1_addr  = addr_in;
         end else begin
            // read/write select is not looked at while advancing
            next_q.cnt      = step;
            next_q.c1_valid = q.active;
            next_q.c1_op    = q.op;
            next_q.c1_addr  = q.base;
            if (order == ssc_pkg::ssc_order_linear) begin
               next_q.c1_addr[1:0] = q.base[1:0] + step;
            end else begin
               next_q.c1_addr[1:0] = q.base[1:0] ^ step;
            end
         end
         // lane enables register on every running edge, burst beats included
         next_q.c1_lanes = lane_en;
         next_q.c2_valid = q.c1_valid;
         next_q.c2_op    = q.c1_op;
         next_q.c2_addr  = q.c1_addr;
         next_q.c2_lanes = q.c1_lanes;
         // output stage: a deselected slot leaves the bus undriven
         next_q.drive = q.c2_valid && (q.c2_op == ssc_pkg::ssc_op_read);
         // unbuilt lanes read as zero so their pins never carry array garbage
         for (int i = 0; i < LMAX; i++) begin
            next_q.dout[i] = rd_data[i*SW +: BW] & {BW{lane_mask[i]}};
            next_q.pout[i] = rd_data[i*SW + BW] & HAS_PARITY & lane_mask[i];
         end
      end
   end

   // synchronous reset; apart from reset, no edge moves anything unless go
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // ----------------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------------
   // data words leave straight from the output register
   assign data_lane_a_out   = q.dout[0];
   assign data_lane_b_out   = q.dout[1];
   assign data_lane_c_out   = q.dout[2];
   assign data_lane_d_out   = q.dout[3];
   assign parity_lane_a_out = q.pout[0];
   assign parity_lane_b_out = q.pout[1];
   assign parity_lane_c_out = q.pout[2];
   assign parity_lane_d_out = q.pout[3];

   // the output enable pin gates the drivers without waiting for a clock;
   // together with the snooze pin, these are the only paths from pin to pin that skip a flip-flop
   assign lane_oe = {LMAX{q.drive && !output_enable_n && !snooze_request}}
                    & lane_mask;
   assign data_lane_a_oe   = lane_oe[0];
   assign data_lane_b_oe   = lane_oe[1];
   assign data_lane_c_oe   = lane_oe[2];
   assign data_lane_d_oe   = lane_oe[3];
   assign parity_lane_a_oe = lane_oe[0] && HAS_PARITY;
   assign parity_lane_b_oe = lane_oe[1] && HAS_PARITY;
   assign parity_lane_c_oe = lane_oe[2] && HAS_PARITY;
   assign parity_lane_d_oe = lane_oe[3] && HAS_PARITY;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   // a selected load issued with the part running
   sequence s_sel_load;
      go && load && selected;
   endsequence

   sequence s_read_load;
      go && load && selected && write_select_n;
   endsequence

   property p_freeze;
      clock_enable_n |=> $stable(q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while clock frozen");

   property p_snooze;
      snooze_request |=> $stable(q);
   endproperty
   a_snooze: assert property (p_snooze) else $error("state moved while snoozing");

   property p_addr_capture;
      go && load |=> q.c1_addr == $past(addr_in) && q.base == $past(addr_in);
   endproperty
   a_addr_capture: assert property (p_addr_capture) else $error("load address lost");

   property p_deselect;
      go && load && (select_one_n || select_two_n) |=> !q.c1_valid;
   endproperty
   a_deselect: assert property (p_deselect) else $error("low select not honoured");

   property p_select_high;
      go && load && !select_three_high ##1 go |-> !q.c1_valid ##1 !q.c2_valid;
   endproperty
   a_select_high: assert property (p_select_high) else $error("high select ignored");

   property p_type_kept;
      go && !load |=> q.c1_op == $past(q.op) && q.op == $past(q.op);
   endproperty
   a_type_kept: assert property (p_type_kept) else $error("burst changed its type");

   property p_wrap;
      go && !load |=> q.c1_addr[ADDR_W-1:2] == $past(q.base[ADDR_W-1:2]);
   endproperty
   a_wrap: assert property (p_wrap) else $error("burst left its four slots");

   property p_write_type;
      s_sel_load |=> (q.c1_op == ssc_pkg::ssc_op_write) == !$past(write_select_n);
   endproperty
   a_write_type: assert property (p_write_type) else $error("wrong access type");

   property p_read_drive;
      s_read_load ##1 go ##1 go |=> q.drive;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read data not staged");

   property p_oe_off;
      output_enable_n || !q.drive |-> !data_lane_a_oe && !parity_lane_a_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("drivers on while disabled");

   property p_lane_write;
      s_sel_load ##0 !write_select_n ##0 !lane_a_write_en_n ##1 go ##1 go
         |-> mem_wr && q.c2_lanes[0];
   endproperty
   a_lane_write: assert property (p_lane_write) else $error("lane a write lost");

   // a deselected load must never reach the output stage
   property p_quiet;
      go && load && !selected ##1 go ##1 go |=> !q.drive;
   endproperty
   a_quiet: assert property (p_quiet) else $error("deselected slot drove data");

   // standby keeps the data pins released whatever the pipeline holds
   property p_nap_off;
      snooze_request |-> !data_lane_a_oe && !data_lane_b_oe;
   endproperty
   a_nap_off: assert property (p_nap_off) else $error("drivers on in snooze");

   // each advance moves the two-bit counter by one, wrapping after four
   property p_step;
      go && !load |=> q.cnt == $past(q.cnt) + 2'd1;
   endproperty
   a_step: assert property (p_step) else $error("burst count skipped");

endmodule

// ### ssc_defs.svh
// constants for the synchronous sram control-input front end
// Summary of operation
// - address inputs are captured into registers on the rising clock edge
// - address, selects, lane enables and burst controls register together; write data is taken two edges later
// - each active-low lane write enable governs one byte lane and its parity bit
// - parity bits exist only in the narrow and 36-bit builds
// - first select is active low, sampled only on address-load cycles
// - second select is active low, sampled only on address-load cycles
// - third select is active high, sampled only on address-load cycles
// - clock enable high freezes every internal state, stretching the cycle
// - snooze request enters standby while keeping the array contents
// - while snoozing every other input is disregarded
// - read/write select at address load alone decides read or write
// - a burst keeps its operation type; only a new load changes it
// - write select low enables lane writes; all lanes low writes full width
// - output enable turns data drivers on when low, off when high, unclocked
// - advance high steps the burst counter, ignoring read/write; low loads
// - burst order select low gives linear order, high gives interleaved
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// ----------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------
`define SSC_ADDR_W_DFLT  18
`define SSC_LANES_DFLT   2
`define SSC_PARITY_DFLT  1
`define SSC_LANES_MAX    4
`define SSC_BYTE_W       8
`define SSC_SLOT_W       9
`define SSC_BURST_W      2

// ----------------------------------------------------------------------
// timing, in clock edges that are not frozen
// ----------------------------------------------------------------------
`define SSC_READ_LAT     2
`define SSC_WRITE_LAT    2

`endif

// ### ssc_pkg.sv
// shared types of the synchronous sram control-input front end
package ssc_pkg;

   // kind of access fixed at address load
   typedef enum logic {
      ssc_op_read,
      ssc_op_write
   } ssc_op_t;

   // burst address sequence
   typedef enum logic {
      ssc_order_linear,
      ssc_order_interleave
   } ssc_order_t;

endpackage

// ### ssc_mem.sv
// storage array with lane writes and a registered read port
`timescale 1ns/100ps
`include "ssc_defs.svh"

module ssc_mem #(
   parameter int ADDR_W = `SSC_ADDR_W_DFLT,
   parameter int LANES  = `SSC_LANES_MAX,
   parameter int SLOT_W = `SSC_SLOT_W
) (
   input  wire logic                      clk_sys,
   input  wire logic                      rd_en,
   input  wire logic [ADDR_W-1:0]         rd_addr,
   output logic      [LANES*SLOT_W-1:0]   rd_data,
   input  wire logic                      wr_en,
   input  wire logic [ADDR_W-1:0]         wr_addr,
   input  wire logic [LANES-1:0]          wr_lane,
   input  wire logic [LANES*SLOT_W-1:0]   wr_data
);

   // ----------------------------------------------------------------------
   // array, one slot per lane, no reset so contents survive everything
   // ----------------------------------------------------------------------
   logic [LANES*SLOT_W-1:0] cells [0:(1<<ADDR_W)-1];

   // lane-granular write; a lane whose enable is low keeps its old value
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         for (int i = 0; i < LANES; i++) begin
            if (wr_lane[i]) begin
               cells[wr_addr][i*SLOT_W +: SLOT_W] <= wr_data[i*SLOT_W +: SLOT_W];
            end
         end
      end
   end

   // read data come from a register; held while rd_en is low
   always_ff @(posedge clk_sys) begin
      if (rd_en) begin
         rd_data <= cells[rd_addr];
      end
   end

endmodule

// ### ssc_ctrl_model.sv
// controller-side model driving command, write-data and output-gate pins
`timescale 1ns/100ps

module ssc_ctrl_model (
   input  wire logic        clk_sys,
   output logic [7:0]       cmd_addr,
   output logic [1:0]       cmd_lanes_n,
   output logic             cmd_sel_one_n,
   output logic             cmd_sel_two_n,
   output logic             cmd_sel_three,
   output logic             cmd_cke_n,
   output logic             cmd_snooze,
   output logic             cmd_write_n,
   output logic             cmd_advance,
   output logic             cmd_order,
   output logic             cmd_oe_n,
   output logic [17:0]      bus_wdata
);
   logic [1:0]  wq_v;
   logic [17:0] wq_d [0:1];

   // ----------------------------------------------------------------
   // idle, deselected and running from time zero
   // ----------------------------------------------------------------
   initial begin
      {cmd_addr, cmd_lanes_n, cmd_write_n, cmd_advance} = 12'hfff;
      {cmd_sel_one_n, cmd_sel_two_n, cmd_sel_three} = 3'b100;
      {cmd_cke_n, cmd_snooze, cmd_order, cmd_oe_n} = 4'h0;
      bus_wdata = 18'h0;
      wq_v = 2'b00;
   end

   // one bus beat; write data trails its command by two running edges
   task automatic beat(input logic ld, input logic wr_n, input logic [7:0] a,
                       input logic [1:0] ln, input logic [2:0] off, input logic wf,
                       input logic [17:0] wd, input logic [1:0] st, input logic ord,
                       input logic oen);
      @(posedge clk_sys);
      cmd_oe_n <= oen;
      cmd_cke_n <= st[0];
      cmd_snooze <= st[1];
      if (st != 2'd0) begin
         // churn on every pin but burst order and output gate so a frozen edge that listens gets caught
         cmd_addr <= ~cmd_addr;
         cmd_advance <= ~cmd_advance;
         cmd_write_n <= ~cmd_write_n;
         cmd_lanes_n <= ~cmd_lanes_n;
         {cmd_sel_one_n, cmd_sel_two_n, cmd_sel_three} <= 3'b011;
         bus_wdata <= ~bus_wdata;
      end else begin
         cmd_addr <= a;
         cmd_advance <= !ld;
         cmd_write_n <= wr_n;
         cmd_lanes_n <= wf ? ln : 2'b11;
         cmd_sel_one_n <= off[0];
         cmd_sel_two_n <= off[1];
         cmd_sel_three <= !off[2];
         cmd_order <= ord;
         // a released bus shows the inverse of its last value, never a stale copy
         bus_wdata <= wq_v[1] ? wq_d[1] : ~bus_wdata;
         wq_v <= {wq_v[0], wf};
         wq_d[1] <= wq_d[0];
         wq_d[0] <= wd;
      end
   endtask
endmodule

// ### ssc_front_tb.sv
// self-checking bench for the synchronous sram control-input front end
`timescale 1ns/100ps

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module ssc_front_tb;
   logic        clk_sys;
   logic        nrst;
   logic [7:0]  c_addr;
   logic [1:0]  c_ln;
   logic [17:0] c_wd;
   logic        c_s1, c_s2, c_s3, c_cke, c_zz, c_wr, c_adv, c_ord, c_oe;
   logic [7:0]  qa, qb, qc, qd;
   logic        pa, pb, pc, pd, oa, ob, opa, opb, oc, od, opc, opd;
   logic [17:0] mem_e [0:255];
   logic [18:0] pq [$];
   logic [18:0] cur;
   logic [17:0] wdv;
   logic [7:0]  av;
   logic [2:0]  ov;
   logic [1:0]  lnv;
   logic [7:0]  b_base;
   logic [1:0]  b_n;
   logic        b_wr, b_sel, prev_run, g_ord, g_oen;
   logic [1:0]  ln_tab [0:3] = '{2'b10, 2'b01, 2'b11, 2'b00};
   int          fails = 0;
   int          check_count = 0;
   int          cyc = 0;
   int          i;

   ssc_front #(.ADDR_W(8), .LANES(2), .HAS_PARITY(1'b1)) dut_u (
      .clk_sys(clk_sys), .nrst(nrst), .addr_bit_zero(c_addr[0]), .addr_bit_one(c_addr[1]),
      .upper_address_inputs(c_addr[7:2]), .lane_a_write_en_n(c_ln[0]),
      .lane_b_write_en_n(c_ln[1]), .lane_c_write_en_n(c_ln[0]), .lane_d_write_en_n(c_ln[1]),
      .select_one_n(c_s1), .select_two_n(c_s2), .select_three_high(c_s3),
      .clock_enable_n(c_cke), .snooze_request(c_zz), .write_select_n(c_wr),
      .advance_or_load(c_adv), .burst_order_select(c_ord), .output_enable_n(c_oe),
      .data_lane_a_in(c_wd[7:0]), .data_lane_b_in(c_wd[15:8]), .data_lane_c_in(c_wd[7:0]),
      .data_lane_d_in(c_wd[15:8]), .data_lane_a_out(qa), .data_lane_b_out(qb),
      .data_lane_c_out(qc), .data_lane_d_out(qd), .data_lane_a_oe(oa), .data_lane_b_oe(ob),
      .data_lane_c_oe(oc), .data_lane_d_oe(od), .parity_lane_a_in(c_wd[16]),
      .parity_lane_b_in(c_wd[17]), .parity_lane_c_in(c_wd[16]), .parity_lane_d_in(c_wd[17]),
      .parity_lane_a_out(pa), .parity_lane_b_out(pb), .parity_lane_c_out(pc),
      .parity_lane_d_out(pd), .parity_lane_a_oe(opa), .parity_lane_b_oe(opb),
      .parity_lane_c_oe(opc), .parity_lane_d_oe(opd));

   ssc_ctrl_model ctrl_u (
      .clk_sys(clk_sys), .cmd_addr(c_addr), .cmd_lanes_n(c_ln), .cmd_sel_one_n(c_s1),
      .cmd_sel_two_n(c_s2), .cmd_sel_three(c_s3), .cmd_cke_n(c_cke), .cmd_snooze(c_zz),
      .cmd_write_n(c_wr), .cmd_advance(c_adv), .cmd_order(c_ord), .cmd_oe_n(c_oe),
      .bus_wdata(c_wd));

   // ----------------------------------------------------------------
   // clock, hang guard and closing report
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // 81 beats are planned after 20 reset edges; the ceiling leaves a wide margin
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // one beat: predict the access, drive it, then check the edge's visible result
   task automatic op(input logic ld, input logic wr_n, input logic [7:0] a,
                     input logic [1:0] ln, input logic [2:0] off, input logic [17:0] wd,
                     input logic [1:0] st);
      logic [7:0] ea;
      if (st == 2'd0) begin
         if (ld) begin
            b_base = a;
            b_n = 2'd0;
            b_wr = !wr_n;
            b_sel = (off == 3'd0);
         end else begin
            b_n = b_n + 2'd1;
         end
         ea = {b_base[7:2], g_ord ? (b_base[1:0] ^ b_n) : (b_base[1:0] + b_n)};
         if (b_sel && b_wr && !ln[0]) {mem_e[ea][16], mem_e[ea][7:0]} = {wd[16], wd[7:0]};
         if (b_sel && b_wr && !ln[1]) {mem_e[ea][17], mem_e[ea][15:8]} = {wd[17], wd[15:8]};
      end
      ctrl_u.beat(ld, wr_n, a, ln, off, b_wr, wd, st, g_ord, g_oen);
      if (prev_run) cur = pq.pop_front();
      #1;
      `CHK("oe_ab", {4{cur[18] & !g_oen & (st != 2'd2)}}, {oa, ob, opa, opb})
      `CHK("oe_cd", 4'h0, {oc, od, opc, opd})
      `CHK("out_cd", 18'h0, {qc, qd, pc, pd})
      if (cur[18]) `CHK("rdata", cur[17:0], {pb, pa, qb, qa})
      if (st == 2'd0) pq.push_back({b_sel & !b_wr, mem_e[ea]});
      prev_run = (st == 2'd0);
   endtask

   task automatic idle(input int n);
      repeat (n) op(1'b1, 1'b1, 8'h00, 2'b11, 3'b001, 18'h0, 2'd0);
   endtask

   task automatic rd_burst(input logic [7:0] a);
      for (int k = 0; k < 4; k++) op(k == 0, k == 0, a, 2'b11, 3'd0, 18'h0, 2'd0);
   endtask

   task automatic end_test(input string nm);
      $display("test %s done", nm);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {nrst, g_ord, g_oen, prev_run, b_wr, b_sel} = 6'h0;
      {cur, b_base, b_n} = '0;
      pq = '{19'h0, 19'h0};
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      #1;
      `CHK("reset", 20'h0, {qa, qb, pa, pb, oa, ob})
      end_test("reset");
      // write burst; write select flips high on advances and must be ignored
      for (i = 0; i < 4; i++) begin
         wdv = 18'(18'h1_2a5a + i * 18'h1111);
         op(i == 0, i[0], 8'h10, 2'b00, 3'd0, wdv, 2'd0);
      end
      idle(2);
      // interleaved read burst, write select low on advances; output gate toggled
      g_ord = 1'b1;
      rd_burst(8'h12);
      for (i = 0; i < 3; i++) begin
         g_oen = (i == 1);
         idle(1);
      end
      g_ord = 1'b0;
      end_test("bursts");
      // full burst then a burst with a different lane mix on each beat, on the same four words
      for (i = 0; i < 8; i++) begin
         wdv = 18'(18'h3_0f0f + i * 18'h2121);
         lnv = (i < 4) ? 2'b00 : ln_tab[i[1:0]];
         op(i[1:0] == 2'd0, 1'b0, 8'h20, lnv, 3'd0, wdv, 2'd0);
      end
      idle(2);
      rd_burst(8'h20);
      idle(3);
      end_test("lanes");
      // back-to-back mix of writes and reads with no turnaround beat
      for (i = 0; i < 8; i++) begin
         av = i[0] ? {6'h04, i[2:1]} : 8'(8'h30 + i);
         op(1'b1, i[0], av, 2'b00, 3'd0, 18'(18'h1_4400 + i), 2'd0);
      end
      idle(2);
      for (i = 0; i < 4; i++) op(1'b1, 1'b1, 8'(8'h30 + 2 * i), 2'b11, 3'd0, 18'h0, 2'd0);
      idle(3);
      end_test("turnaround");
      // each select inactive in turn: deselected write and read bursts
      for (i = 0; i < 3; i++) begin
         ov = 3'(1 << i);
         op(1'b1, 1'b0, 8'h10, 2'b00, ov, 18'h3_ffff, 2'd0);
         op(1'b0, 1'b1, 8'h10, 2'b00, 3'd0, 18'h3_ffff, 2'd0);
         op(1'b1, 1'b1, 8'h10, 2'b11, ov, 18'h0, 2'd0);
         op(1'b0, 1'b0, 8'h10, 2'b11, 3'd0, 18'h0, 2'd0);
      end
      idle(2);
      rd_burst(8'h10);
      idle(3);
      end_test("selects");
      // frozen and snoozed edges inside write and read pipelines
      op(1'b1, 1'b0, 8'h40, 2'b00, 3'd0, 18'h2_5a3c, 2'd0);
      op(1'b0, 1'b0, 8'h00, 2'b00, 3'd0, 18'h0, 2'd1);
      op(1'b0, 1'b0, 8'h00, 2'b00, 3'd0, 18'h0, 2'd2);
      idle(2);
      op(1'b1, 1'b1, 8'h40, 2'b11, 3'd0, 18'h0, 2'd0);
      idle(1);
      op(1'b0, 1'b0, 8'h00, 2'b00, 3'd0, 18'h0, 2'd1);
      op(1'b0, 1'b0, 8'h00, 2'b00, 3'd0, 18'h0, 2'd2);
      idle(4);
      end_test("freeze");
      finish_test();
   end
endmodule
